// ---- design/gsp_status_poll.sv ----
`timescale 1ns/1ns
`include "gsp_map.svh"
module gsp_status_poll #(
  parameter int unsigned CHANNELS = 2,
  parameter longint unsigned TEST_CYCLES = `GSP_TST_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire gsp_pkg::gsp_req_s req,
  input wire gsp_pkg::gsp_cond_s cond,
  input wire logic listen_addr,
  input wire logic talk_addr,
  input wire logic talk_rd,
  input wire logic poll_active,
  input wire logic trig_src_bus,
  input wire logic [CHANNELS-1:0] chan_waiting,
  input wire logic ops_pending,
  input wire logic test_fail,
  input wire logic [7:0] talk_data,
  output gsp_pkg::gsp_resp_s resp,
  output logic busy,
  output logic [7:0] poll_line,
  output logic [7:0] poll_line_oe,
  output logic srq,
  output logic [7:0] talk_out,
  output logic [CHANNELS-1:0] chan_trig,
  output logic ddt_query,
  output logic err_valid,
  output logic [15:0] err_code,
  output logic parser_reset,
  output logic out_flush,
  output logic remote,
  output logic lockout,
  output logic free_run,
  output logic [3:0] save_slot,
  output logic save_go
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8)
      $error("gsp_status_poll: CHANNELS must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////
  // Status byte and summary, combinational; srq registers the summary one clock later
  logic [7:0] srm;
  logic [7:0] stb_raw;
  logic [7:0] stb_live;
  logic mss;
  always_comb begin
    stb_raw = 8'h00;
    stb_raw[`GSP_STB_DEV] = cond.dev;
    stb_raw[`GSP_STB_ERRQ] = cond.errq;
    stb_raw[`GSP_STB_QUES] = cond.ques;
    stb_raw[`GSP_STB_MAV] = cond.mav;
    stb_raw[`GSP_STB_ESB] = cond.esb;
    stb_raw[`GSP_STB_OPER] = cond.oper;
    mss = |(stb_raw & srm & `GSP_SRM_KEEP);
    stb_live = stb_raw;
    stb_live[`GSP_STB_MSS] = mss;
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  gsp_pkg::gsp_state_e state;
  gsp_pkg::gsp_state_e next_state;
  gsp_pkg::gsp_req_s held;
  gsp_pkg::gsp_req_s next_held;
  logic held_valid;
  logic next_held_valid;
  logic pp_cfg_pend;
  logic next_pp_cfg_pend;
  logic pp_en;
  logic next_pp_en;
  logic [3:0] pp_cfg;
  logic [3:0] next_pp_cfg;
  logic spoll;
  logic next_spoll;
  logic ddt_alt;
  logic next_ddt_alt;
  gsp_pkg::gsp_resp_s next_resp;
  logic [CHANNELS-1:0] next_chan_trig;
  logic next_ddt_query;
  logic next_err_valid;
  logic next_parser_reset;
  logic next_out_flush;
  logic next_remote;
  logic next_lockout;
  logic next_free_run;
  logic [3:0] next_save_slot;
  logic next_save_go;
  logic tst_start;
  logic tst_abort;
  logic tst_busy;
  logic tst_done;
  logic tst_failed;
  logic clear_now;
  gsp_pkg::gsp_req_s cur;

  gsp_self_test #(.TEST_CYCLES(TEST_CYCLES)) u_test (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(tst_start),
    .abort(tst_abort),
    .fail_in(test_fail),
    .busy(tst_busy),
    .done(tst_done),
    .failed(tst_failed)
  );

  always_comb begin
    next_state = state;
    next_held = held;
    next_held_valid = held_valid;
    next_pp_cfg_pend = pp_cfg_pend;
    next_pp_en = pp_en;
    next_pp_cfg = pp_cfg;
    next_spoll = spoll;
    next_ddt_alt = ddt_alt;
    next_resp = '0;
    next_chan_trig = '0;
    next_ddt_query = 1'b0;
    next_err_valid = 1'b0;
    next_parser_reset = 1'b0;
    next_out_flush = 1'b0;
    next_remote = remote;
    next_lockout = lockout;
    next_free_run = free_run;
    next_save_slot = save_slot;
    next_save_go = 1'b0;
    tst_start = 1'b0;
    tst_abort = 1'b0;
    // Only device clears (DCL, or SDC while listening) bypass the wait hold; one other command is held, later ones are dropped
    cur = req;
    if (state == gsp_pkg::GSP_ST_IDLE && held_valid) begin
      cur = held;
      next_held_valid = 1'b0;
    end
    clear_now = (req.cmd == gsp_pkg::GSP_CMD_DCL) ||
      (req.cmd == gsp_pkg::GSP_CMD_SDC && listen_addr);
    if (clear_now) begin
      next_state = gsp_pkg::GSP_ST_IDLE;
      next_held_valid = 1'b0;
      next_parser_reset = 1'b1;
      next_out_flush = 1'b1;
      tst_abort = 1'b1;
    end else if (state != gsp_pkg::GSP_ST_IDLE) begin
      if (state == gsp_pkg::GSP_ST_WAIT && !ops_pending)
        next_state = gsp_pkg::GSP_ST_IDLE;
      if (state == gsp_pkg::GSP_ST_TEST && tst_done) begin
        next_state = gsp_pkg::GSP_ST_IDLE;
        next_resp.valid = 1'b1;
        next_resp.data = tst_failed ? `GSP_TST_FAIL : `GSP_TST_PASS;
      end
      if (req.cmd != gsp_pkg::GSP_CMD_NONE && !held_valid) begin
        next_held = req;
        next_held_valid = 1'b1;
      end
    end else begin
      if (cur.cmd != gsp_pkg::GSP_CMD_PP2)
        next_pp_cfg_pend = 1'b0;
      case (cur.cmd)
        gsp_pkg::GSP_CMD_SRE_WR: begin
          next_held.data = cur.data; // keeps case complete
        end
        gsp_pkg::GSP_CMD_SRE_RD: begin
          next_resp.valid = 1'b1;
          next_resp.data = srm & `GSP_SRM_KEEP;
        end
        gsp_pkg::GSP_CMD_STB_RD: begin
          next_resp.valid = 1'b1;
          next_resp.data = stb_live;
        end
        gsp_pkg::GSP_CMD_TRG, gsp_pkg::GSP_CMD_GET: begin
          if (!trig_src_bus || chan_waiting == '0) begin
            next_err_valid = 1'b1;
          end else begin
            next_chan_trig = chan_waiting;
            next_ddt_query = ddt_alt;
          end
        end
        gsp_pkg::GSP_CMD_DDT: begin
          next_ddt_alt = cur.data[0];
        end
        gsp_pkg::GSP_CMD_TST: begin
          tst_start = 1'b1;
          next_state = gsp_pkg::GSP_ST_TEST;
        end
        gsp_pkg::GSP_CMD_WAI: begin
          if (ops_pending)
            next_state = gsp_pkg::GSP_ST_WAIT;
        end
        gsp_pkg::GSP_CMD_REN: begin
          next_remote = 1'b1;
        end
        gsp_pkg::GSP_CMD_GTL: begin
          next_remote = 1'b0;
          next_lockout = 1'b0;
          next_free_run = 1'b1;
        end
        gsp_pkg::GSP_CMD_LLO: begin
          next_lockout = 1'b1;
        end
        gsp_pkg::GSP_CMD_PPC: begin
          next_pp_cfg_pend = listen_addr;
        end
        gsp_pkg::GSP_CMD_PP2: begin
          next_pp_cfg_pend = 1'b0;
          if (pp_cfg_pend) begin
            if (cur.data == `GSP_PPD_BYTE) begin
              next_pp_en = 1'b0;
            end else if (cur.data[7:4] == `GSP_PPE_TAG) begin
              next_pp_en = 1'b1;
              next_pp_cfg = cur.data[3:0];
            end
          end
        end
        gsp_pkg::GSP_CMD_PPU: begin
          next_pp_en = 1'b0;
        end
        gsp_pkg::GSP_CMD_SPE: begin
          next_spoll = 1'b1;
        end
        gsp_pkg::GSP_CMD_SPD: begin
          next_spoll = 1'b0;
        end
        gsp_pkg::GSP_CMD_SAV: begin
          if (cur.data[7:4] == 4'h0 && cur.data[3:0] >= `GSP_SLOT_MIN &&
              cur.data[3:0] <= `GSP_SLOT_MAX) begin
            next_save_slot = cur.data[3:0];
            next_save_go = 1'b1;
          end
        end
        default: begin
          next_held = held;
        end
      endcase
      if (cur.cmd == gsp_pkg::GSP_CMD_GTL)
        next_free_run = 1'b1;
      else if (cur.cmd == gsp_pkg::GSP_CMD_TRG ||
               cur.cmd == gsp_pkg::GSP_CMD_GET)
        next_free_run = free_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask register; write only when the sequencer takes the command
  logic [7:0] next_srm;
  always_comb begin
    next_srm = srm;
    if (state == gsp_pkg::GSP_ST_IDLE && !clear_now &&
        cur.cmd == gsp_pkg::GSP_CMD_SRE_WR)
      next_srm = cur.data & `GSP_SRM_KEEP;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers: poll lines, request line and talker byte
  logic [7:0] next_poll_line;
  logic [7:0] next_poll_line_oe;
  logic [7:0] next_talk_out;
  always_comb begin
    next_poll_line = 8'h00;
    next_poll_line_oe = 8'h00;
    if (poll_active && pp_en && mss) begin
      next_poll_line_oe[pp_cfg[2:0]] = 1'b1;
      next_poll_line[pp_cfg[2:0]] = pp_cfg[`GSP_PP_SENSE];
    end
    // Serial poll substitutes the status byte for device data
    if (talk_addr && talk_rd && spoll)
      next_talk_out = stb_live;
    else
      next_talk_out = talk_data;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= gsp_pkg::GSP_ST_IDLE;
      held <= '0;
      held_valid <= 1'b0;
      pp_cfg_pend <= 1'b0;
      pp_en <= 1'b0;
      pp_cfg <= 4'h0;
      spoll <= 1'b0;
      ddt_alt <= 1'b0;
      srm <= `GSP_SRM_RESET;
      resp <= '0;
      chan_trig <= '0;
      ddt_query <= 1'b0;
      err_valid <= 1'b0;
      err_code <= `GSP_ERR_TRIG_IGN;
      parser_reset <= 1'b0;
      out_flush <= 1'b0;
      remote <= 1'b0;
      lockout <= 1'b0;
      free_run <= 1'b1;
      save_slot <= `GSP_SLOT_MIN;
      save_go <= 1'b0;
      poll_line <= 8'h00;
      poll_line_oe <= 8'h00;
      srq <= 1'b0;
      talk_out <= 8'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      held_valid <= next_held_valid;
      pp_cfg_pend <= next_pp_cfg_pend;
      pp_en <= next_pp_en;
      pp_cfg <= next_pp_cfg;
      spoll <= next_spoll;
      ddt_alt <= next_ddt_alt;
      srm <= next_srm;
      resp <= next_resp;
      chan_trig <= next_chan_trig;
      ddt_query <= next_ddt_query;
      err_valid <= next_err_valid;
      err_code <= `GSP_ERR_TRIG_IGN;
      parser_reset <= next_parser_reset;
      out_flush <= next_out_flush;
      remote <= next_remote;
      lockout <= next_lockout;
      free_run <= next_free_run;
      save_slot <= next_save_slot;
      save_go <= next_save_go;
      poll_line <= next_poll_line;
      poll_line_oe <= next_poll_line_oe;
      srq <= mss;
      talk_out <= next_talk_out;
      busy <= (next_state != gsp_pkg::GSP_ST_IDLE) || next_held_valid;
    end
  end
endmodule // gsp_status_poll

// ---- inc/gsp_map.svh ----
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH
// Service request mask
`define GSP_SRM_KEEP 8'hbf
`define GSP_SRM_RESET 8'h00
// Status byte bit positions
`define GSP_STB_DEV 1
`define GSP_STB_ERRQ 2
`define GSP_STB_QUES 3
`define GSP_STB_MAV 4
`define GSP_STB_ESB 5
`define GSP_STB_MSS 6
`define GSP_STB_OPER 7
// Parallel poll secondary bytes
`define GSP_PPE_TAG 4'h6
`define GSP_PPD_BYTE 8'h70
`define GSP_PP_SENSE 3
// Error codes, two's complement 16 bit
`define GSP_ERR_TRIG_IGN 16'hff2d
// Self-test result
`define GSP_TST_PASS 8'h00
`define GSP_TST_FAIL 8'h01
// Self-test time in seconds and cycles at 250 MHz
`define GSP_TST_SEC 100
`define GSP_CLK_HZ 250000000
`define GSP_TST_CYC (`GSP_TST_SEC * 64'd250000000)
// Save slots
`define GSP_SLOT_MIN 4'h1
`define GSP_SLOT_MAX 4'ha
`endif

// ---- inc/gsp_pkg.sv ----
package gsp_pkg;
  typedef enum logic [4:0] {
    GSP_CMD_NONE = 5'b00000,
    GSP_CMD_SRE_WR = 5'b00001,
    GSP_CMD_SRE_RD = 5'b00010,
    GSP_CMD_STB_RD = 5'b00011,
    GSP_CMD_TRG = 5'b00100,
    GSP_CMD_GET = 5'b00101,
    GSP_CMD_TST = 5'b00110,
    GSP_CMD_WAI = 5'b00111,
    GSP_CMD_DCL = 5'b01000,
    GSP_CMD_SDC = 5'b01001,
    GSP_CMD_GTL = 5'b01010,
    GSP_CMD_LLO = 5'b01011,
    GSP_CMD_PPC = 5'b01100,
    GSP_CMD_PP2 = 5'b01101,
    GSP_CMD_PPU = 5'b01110,
    GSP_CMD_SPE = 5'b01111,
    GSP_CMD_SPD = 5'b10000,
    GSP_CMD_SAV = 5'b10001,
    GSP_CMD_DDT = 5'b10010,
    GSP_CMD_REN = 5'b10011
  } gsp_cmd_e;
  typedef enum logic [1:0] {
    GSP_ST_IDLE = 2'b00,
    GSP_ST_WAIT = 2'b01,
    GSP_ST_TEST = 2'b10
  } gsp_state_e;
  typedef struct packed {
    gsp_cmd_e cmd;
    logic [7:0] data;
  } gsp_req_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } gsp_resp_s;
  typedef struct packed {
    logic dev;
    logic errq;
    logic ques;
    logic mav;
    logic esb;
    logic oper;
  } gsp_cond_s;
endpackage

// ---- design/gsp_self_test.sv ----
`timescale 1ns/1ns
`include "gsp_map.svh"
module gsp_self_test #(
  parameter longint unsigned TEST_CYCLES = `GSP_TST_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  input wire logic fail_in,
  output logic busy,
  output logic done,
  output logic failed
);
  logic [39:0] cnt;
  logic [39:0] next_cnt;
  logic next_busy;
  logic next_done;
  logic next_failed;
  initial begin
    if (TEST_CYCLES < 1 || TEST_CYCLES > 64'hff_ffff_ffff)
      $error("gsp_self_test: TEST_CYCLES out of range");
  end
  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_failed = failed;
    if (abort) begin
      next_busy = 1'b0;
      next_cnt = 40'h0;
    end else if (start && !busy) begin
      next_busy = 1'b1;
      next_cnt = 40'h0;
      next_failed = 1'b0;
    end else if (busy) begin
      if (fail_in)
        next_failed = 1'b1;
      if (cnt == 40'(TEST_CYCLES - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 40'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt <= 40'h0;
      busy <= 1'b0;
      done <= 1'b0;
      failed <= 1'b0;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      failed <= next_failed;
    end
  end
endmodule // gsp_self_test

// ---- tb/gsp_status_poll_sva.sv ----
`timescale 1ns/1ns
module gsp_sp_sva #(
  parameter int unsigned CHANNELS = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire gsp_pkg::gsp_req_s req,
  input wire logic listen_addr,
  input wire logic trig_src_bus,
  input wire logic [CHANNELS-1:0] chan_waiting,
  input wire gsp_pkg::gsp_resp_s resp,
  input wire logic busy,
  input wire logic [7:0] poll_line_oe,
  input wire logic [CHANNELS-1:0] chan_trig,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic parser_reset,
  input wire logic out_flush,
  input wire logic lockout
);
  logic trg_cmd;
  // Held commands are judged by the bench; trg_cmd marks only idle takes
  assign trg_cmd = !busy && (req.cmd == gsp_pkg::GSP_CMD_TRG ||
    req.cmd == gsp_pkg::GSP_CMD_GET);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_trig_fires: assert property (
    trg_cmd && trig_src_bus && |chan_waiting |=>
      chan_trig == $past(chan_waiting) && !err_valid)
    else $error("trigger missed waiting channels");
  a_trig_ignored: assert property (
    trg_cmd && !(trig_src_bus && |chan_waiting) |=>
      err_valid && chan_trig == '0)
    else $error("ignored trigger not logged");
  a_err_code: assert property (
    err_code == 16'hff2d)
    else $error("error code wrong");
  a_wait_holds: assert property (
    busy && req.cmd == gsp_pkg::GSP_CMD_TRG |=> chan_trig == '0)
    else $error("trigger ran while waiting");
  a_dcl_clears: assert property (
    req.cmd == gsp_pkg::GSP_CMD_DCL |=> parser_reset && out_flush)
    else $error("device clear incomplete");
  a_sdc_listen: assert property (
    req.cmd == gsp_pkg::GSP_CMD_SDC |=> out_flush == $past(listen_addr))
    else $error("selected clear ignores listen state");
  a_llo_locks: assert property (
    !busy && req.cmd == gsp_pkg::GSP_CMD_LLO |=> lockout)
    else $error("lockout not set");
  a_pp_onehot: assert property (
    $onehot0(poll_line_oe))
    else $error("more than one poll line driven");
  a_mask_bit6: assert property (
    !busy && req.cmd == gsp_pkg::GSP_CMD_SRE_RD |=>
      resp.valid && !resp.data[6])
    else $error("mask read bad");
  c_trig: cover property (trg_cmd ##1 |chan_trig);
  c_resp: cover property (resp.valid);
  c_poll: cover property (|poll_line_oe);
endmodule // gsp_sp_sva

bind gsp_status_poll gsp_sp_sva #(.CHANNELS(CHANNELS)) u_sva (
  .ref_clk(ref_clk), .reset_n(reset_n), .req(req),
  .listen_addr(listen_addr), .trig_src_bus(trig_src_bus),
  .chan_waiting(chan_waiting), .resp(resp), .busy(busy),
  .poll_line_oe(poll_line_oe), .chan_trig(chan_trig),
  .err_valid(err_valid), .err_code(err_code),
  .parser_reset(parser_reset), .out_flush(out_flush), .lockout(lockout));

// ---- tb/gsp_host.sv ----
`timescale 1ns/1ns
module gsp_host (
  input wire logic ref_clk,
  input wire gsp_pkg::gsp_resp_s resp,
  output gsp_pkg::gsp_req_s req,
  output logic listen_addr,
  output logic talk_addr,
  output logic talk_rd,
  output logic poll_active
);
  gsp_pkg::gsp_resp_s last;
  initial begin
    req = '0;
    listen_addr = 1'b0;
    talk_addr = 1'b0;
    talk_rd = 1'b0;
    poll_active = 1'b0;
  end
  task automatic set_addr(input logic l, input logic t, input logic p);
    @(posedge ref_clk);
    listen_addr <= l;
    talk_addr <= t;
    talk_rd <= t;
    poll_active <= p;
  endtask
  // Answers and pulses are read once the take edge has settled
  task automatic send(input gsp_pkg::gsp_cmd_e c, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{c, d};
    @(posedge ref_clk);
    req <= '{gsp_pkg::GSP_CMD_NONE, 8'h00};
    #1 last = resp;
  endtask
  task automatic pp_config(input logic [7:0] pp2);
    @(posedge ref_clk);
    listen_addr <= 1'b1;
    req <= '{gsp_pkg::GSP_CMD_PPC, 8'h00};
    @(posedge ref_clk);
    req <= '{gsp_pkg::GSP_CMD_PP2, pp2};
    @(posedge ref_clk);
    req <= '{gsp_pkg::GSP_CMD_NONE, 8'h00};
  endtask
endmodule // gsp_host

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, reset_n, trig_src_bus, ops_pending, test_fail;
  gsp_pkg::gsp_cond_s cond;
  logic [1:0] chan_waiting, chan_trig;
  logic [7:0] talk_data, poll_line, poll_line_oe, talk_out;
  gsp_pkg::gsp_req_s req;
  gsp_pkg::gsp_resp_s resp;
  logic listen_addr, talk_addr, talk_rd, poll_active, busy, srq;
  logic ddt_query, err_valid, parser_reset, out_flush, save_go;
  logic remote, lockout, free_run;
  logic [15:0] err_code;
  logic [3:0] save_slot;
  int fail_count = 0;
  int n_compared = 0;
  gsp_host u_host (.ref_clk(ref_clk), .resp(resp), .req(req),
    .listen_addr(listen_addr), .talk_addr(talk_addr), .talk_rd(talk_rd),
    .poll_active(poll_active));
  gsp_status_poll #(.CHANNELS(2), .TEST_CYCLES(10)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .req(req), .cond(cond),
    .listen_addr(listen_addr), .talk_addr(talk_addr), .talk_rd(talk_rd),
    .poll_active(poll_active), .trig_src_bus(trig_src_bus),
    .chan_waiting(chan_waiting), .ops_pending(ops_pending),
    .test_fail(test_fail), .talk_data(talk_data), .resp(resp),
    .busy(busy), .poll_line(poll_line), .poll_line_oe(poll_line_oe),
    .srq(srq), .talk_out(talk_out), .chan_trig(chan_trig),
    .ddt_query(ddt_query), .err_valid(err_valid), .err_code(err_code),
    .parser_reset(parser_reset), .out_flush(out_flush), .remote(remote),
    .lockout(lockout), .free_run(free_run), .save_slot(save_slot),
    .save_go(save_go));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_mask();
    logic [7:0] w [4] = '{8'hff, 8'h40, 8'h3f, 8'hc1};
    check("slot_rst", save_slot, 4'h1);
    check("err_code", err_code, 16'hff2d);
    foreach (w[i]) begin
      u_host.send(gsp_pkg::GSP_CMD_SRE_WR, w[i]);
      u_host.send(gsp_pkg::GSP_CMD_SRE_RD, 8'h00);
      check("mask", u_host.last, {1'b1, w[i] & 8'hbf});
    end
  endtask
  task automatic t_status();
    int pos [6] = '{1, 2, 3, 4, 5, 7};
    logic [7:0] b;
    foreach (pos[i]) begin
      b = 8'h01 << pos[i];
      @(posedge ref_clk) cond <= 6'h20 >> i;
      u_host.send(gsp_pkg::GSP_CMD_SRE_WR, b);
      u_host.send(gsp_pkg::GSP_CMD_STB_RD, 8'h00);
      check("stb_on", u_host.last.data, b | 8'h40);
      check("srq_on", srq, 1'b1);
      u_host.send(gsp_pkg::GSP_CMD_SRE_WR, ~b);
      u_host.send(gsp_pkg::GSP_CMD_STB_RD, 8'h00);
      check("stb_off", u_host.last.data, b);
      check("srq_off", srq, 1'b0);
    end
  endtask
  task automatic t_trigger();
    gsp_pkg::gsp_cmd_e c [2] = '{gsp_pkg::GSP_CMD_TRG, gsp_pkg::GSP_CMD_GET};
    foreach (c[i]) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk) trig_src_bus <= (k != 2);
        chan_waiting <= (k == 1) ? 2'b00 : 2'b10;
        u_host.send(c[i], 8'h00);
        check("trig", chan_trig, (k == 0) ? 2'b10 : 2'b00);
        check("ignored", err_valid, k != 0);
        check("ddt_rst", ddt_query, 1'b0);
      end
    end
    @(posedge ref_clk) trig_src_bus <= 1'b1;
    u_host.send(gsp_pkg::GSP_CMD_DDT, 8'h01);
    u_host.send(gsp_pkg::GSP_CMD_TRG, 8'h00);
    check("ddt_on", ddt_query, 1'b1);
    u_host.send(gsp_pkg::GSP_CMD_DDT, 8'h00);
  endtask
  task automatic t_wait();
    int n = 0;
    @(posedge ref_clk) ops_pending <= 1'b1;
    u_host.send(gsp_pkg::GSP_CMD_WAI, 8'h00);
    u_host.send(gsp_pkg::GSP_CMD_TRG, 8'h00);
    check("held", {busy, chan_trig}, 3'b100);
    @(posedge ref_clk) ops_pending <= 1'b0;
    while (chan_trig !== 2'b10 && n < 8) begin
      tick();
      n++;
    end
    check("released", chan_trig, 2'b10);
    @(posedge ref_clk) ops_pending <= 1'b1;
    u_host.send(gsp_pkg::GSP_CMD_WAI, 8'h00);
    check("waiting", busy, 1'b1);
    u_host.send(gsp_pkg::GSP_CMD_DCL, 8'h00);
    check("flush", {parser_reset, out_flush}, 2'b11);
    tick();
    check("abort", busy, 1'b0);
    @(posedge ref_clk) ops_pending <= 1'b0;
    for (int l = 0; l < 2; l++) begin
      u_host.set_addr(l[0], 1'b0, 1'b0);
      u_host.send(gsp_pkg::GSP_CMD_SDC, 8'h00);
      check("sdc", {parser_reset, out_flush}, {2{l[0]}});
    end
  endtask
  task automatic t_local();
    u_host.send(gsp_pkg::GSP_CMD_REN, 8'h00);
    u_host.send(gsp_pkg::GSP_CMD_LLO, 8'h00);
    check("lock", {remote, lockout}, 2'b11);
    u_host.send(gsp_pkg::GSP_CMD_GTL, 8'h00);
    check("local", {remote, lockout, free_run}, 3'b001);
  endtask
  task automatic pp_look(input logic [7:0] oe, input logic [7:0] lvl);
    tick();
    tick();
    check("pp_oe", poll_line_oe, oe);
    check("pp_lvl", poll_line & poll_line_oe, lvl);
  endtask
  task automatic t_poll();
    @(posedge ref_clk) cond <= 6'h04;
    u_host.send(gsp_pkg::GSP_CMD_SRE_WR, 8'h10);
    u_host.set_addr(1'b1, 1'b0, 1'b1);
    u_host.pp_config(8'h6d);
    pp_look(8'h20, 8'h20);
    u_host.pp_config(8'h62);
    pp_look(8'h04, 8'h00);
    u_host.pp_config(8'h70);
    pp_look(8'h00, 8'h00);
    u_host.pp_config(8'h6d);
    u_host.send(gsp_pkg::GSP_CMD_PPU, 8'h00);
    pp_look(8'h00, 8'h00);
    u_host.set_addr(1'b0, 1'b1, 1'b0);
    u_host.send(gsp_pkg::GSP_CMD_SPE, 8'h00);
    tick();
    check("spoll", talk_out, 8'h50);
    u_host.send(gsp_pkg::GSP_CMD_SPD, 8'h00);
    tick();
    check("normal", talk_out, 8'h5a);
    // Fresh device data must pass straight through once polling is off
    @(posedge ref_clk) talk_data <= 8'ha5;
    tick();
    check("normal_new", talk_out, 8'ha5);
  endtask
  task automatic t_save_test();
    logic [3:0] s [4] = '{4'h0, 4'h1, 4'ha, 4'hb};
    // Out of range slots leave the last accepted slot and give no pulse
    logic [4:0] e [4] = '{5'h01, 5'h11, 5'h1a, 5'h0a};
    int n;
    foreach (s[i]) begin
      u_host.send(gsp_pkg::GSP_CMD_SAV, {4'h0, s[i]});
      check("save", {save_go, save_slot}, e[i]);
    end
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk) test_fail <= f[0];
      u_host.send(gsp_pkg::GSP_CMD_TST, 8'h00);
      n = 0;
      while (resp.valid !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      check("tst", resp, {1'b1, 7'h00, f[0]});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    cond = '0;
    trig_src_bus = 1'b1;
    chan_waiting = 2'b00;
    ops_pending = 1'b0;
    test_fail = 1'b0;
    talk_data = 8'h5a;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick();
    t_mask();
    t_status();
    t_trigger();
    t_wait();
    t_local();
    t_poll();
    t_save_test();
    stop_test();
  end
  // The run needs well under a thousand cycles; this bound is ten times that
  initial begin
    #40000;
    fail_count++;
    stop_test();
  end
endmodule // tb_top
